// >>> common/uemr_defines.svh
/*
 * Constants of the endpoint mode responder: register byte offsets,
 * field positions, mode encodings and reset values.
 * Assumes it is included by bare name from the design files; the package does not include it.
 */
`ifndef UEMR_DEFINES_SVH
`define UEMR_DEFINES_SVH

// register byte offsets on the bus
`define UEMR_OFS_CTRL_MODE 5'h00
`define UEMR_OFS_DATA_MODE 5'h04
`define UEMR_OFS_CTRL_CNT 5'h08
`define UEMR_OFS_DATA_CNT 5'h0C
`define UEMR_OFS_IRQ_EN 5'h10

// field positions
`define UEMR_STALL_BIT 7
`define UEMR_CNT_MSB 3
`define UEMR_IEN_CTRL_BIT 0
`define UEMR_IEN_DATA_MSB 2
`define UEMR_IEN_DATA_LSB 1

// mode encodings
`define UEMR_MODE_DISABLED 4'h0
`define UEMR_MODE_NAK_INOUT 4'h1
`define UEMR_MODE_STATUS_OUT 4'h2
`define UEMR_MODE_STALL_INOUT 4'h3
`define UEMR_MODE_IGNORE_INOUT 4'h4
`define UEMR_MODE_RSVD_5 4'h5
`define UEMR_MODE_STATUS_IN 4'h6
`define UEMR_MODE_RSVD_7 4'h7
`define UEMR_MODE_NAK_OUT 4'h8
`define UEMR_MODE_ACK_OUT 4'h9
`define UEMR_MODE_NAKOUT_STIN 4'hA
`define UEMR_MODE_ACKOUT_NAKIN 4'hB
`define UEMR_MODE_NAK_IN 4'hC
`define UEMR_MODE_ACK_IN 4'hD
`define UEMR_MODE_NAKIN_STOUT 4'hE
`define UEMR_MODE_ACKIN_STOUT 4'hF

// reset values
`define UEMR_RST_MODE 4'h0
`define UEMR_RST_CNT 4'h0
`define UEMR_RST_IEN 3'h0

`endif

// >>> common/uemr_pkg.sv
/*
 * Types shared by the endpoint mode responder and its decoder.
 * Assumes the defines header is on the include path.
 */
`default_nettype none
package uemr_pkg;
	// token kind delivered by the packet front end
	typedef enum logic [1:0] {
		UEMR_PID_SETUP,
		UEMR_PID_IN,
		UEMR_PID_OUT
	} uemr_pid_t;

	// answer handed back to the packet front end
	typedef enum logic [2:0] {
		UEMR_RESP_NONE,
		UEMR_RESP_ACK,
		UEMR_RESP_NAK,
		UEMR_RESP_STALL,
		UEMR_RESP_TX0,
		UEMR_RESP_TXCNT
	} uemr_resp_t;

	// per mode behaviour toward OUT
	typedef enum logic [2:0] {
		UEMR_OUT_IGNORE,
		UEMR_OUT_NAK,
		UEMR_OUT_STALL,
		UEMR_OUT_ACK,
		UEMR_OUT_CHECK
	} uemr_out_t;

	// whole state of the responder
	typedef struct packed {
		logic [3:0] ctrl_mode;
		logic [3:0] data_mode;
		logic data_stall;
		logic [3:0] ctrl_cnt;
		logic [3:0] data_cnt;
		logic [2:0] irq_en;
		logic avs_wait;
		logic [31:0] rdata;
		logic resp_valid;
		uemr_resp_t resp;
		logic [3:0] tx_count;
		logic ctrl_irq;
		logic data_irq;
	} uemr_state_t;
endpackage
`default_nettype wire

// >>> hw/uemr_mode_decode.sv
/*
 * Mode decoder: turns an endpoint mode, its stall bit and the token with
 * its data packet status into the answer. Purely combinational.
 * Assumes inputs are stable in the cycle the token is presented.
 */
`default_nettype none
`include "uemr_defines.svh"
module uemr_mode_decode (
	// endpoint setting
	input wire logic [3:0] i_mode,
	input wire logic i_stall,
	// token and data packet status
	input wire uemr_pkg::uemr_pid_t i_pid,
	input wire logic i_pkt_valid,
	input wire logic i_pkt_zero_len,
	input wire logic i_pkt_toggle,
	// answer
	output uemr_pkg::uemr_resp_t o_resp,
	output logic o_setup_accept,
	output logic o_out_ack_mode
);
	import uemr_pkg::*;

	uemr_resp_t in_resp;
	uemr_out_t out_kind;

	// mode table: SETUP acceptance, IN answer, OUT behaviour
	always_comb begin
		o_setup_accept = 1'b0;
		in_resp = UEMR_RESP_NONE;
		out_kind = UEMR_OUT_IGNORE;
		case (i_mode)
			`UEMR_MODE_DISABLED: begin
				o_setup_accept = 1'b0;
			end
			`UEMR_MODE_NAK_INOUT: begin
				o_setup_accept = 1'b1;
				in_resp = UEMR_RESP_NAK;
				out_kind = UEMR_OUT_NAK;
			end
			`UEMR_MODE_STATUS_OUT: begin
				o_setup_accept = 1'b1;
				in_resp = UEMR_RESP_STALL;
				out_kind = UEMR_OUT_CHECK;
			end
			`UEMR_MODE_STALL_INOUT: begin
				o_setup_accept = 1'b1;
				in_resp = UEMR_RESP_STALL;
				out_kind = UEMR_OUT_STALL;
			end
			`UEMR_MODE_IGNORE_INOUT: begin
				o_setup_accept = 1'b1;
			end
			`UEMR_MODE_RSVD_5: begin
				out_kind = UEMR_OUT_ACK; // unsupported; still ACKs a valid OUT
			end
			`UEMR_MODE_STATUS_IN: begin
				o_setup_accept = 1'b1;
				in_resp = UEMR_RESP_TX0;
				out_kind = UEMR_OUT_STALL;
			end
			`UEMR_MODE_RSVD_7: begin
				in_resp = UEMR_RESP_TXCNT;
			end
			`UEMR_MODE_NAK_OUT: begin
				out_kind = UEMR_OUT_NAK;
			end
			`UEMR_MODE_ACK_OUT: begin
				out_kind = i_stall ? UEMR_OUT_STALL : UEMR_OUT_ACK;
			end
			`UEMR_MODE_NAKOUT_STIN: begin
				o_setup_accept = 1'b1;
				in_resp = UEMR_RESP_TX0;
				out_kind = UEMR_OUT_NAK;
			end
			`UEMR_MODE_ACKOUT_NAKIN: begin
				o_setup_accept = 1'b1;
				in_resp = UEMR_RESP_NAK;
				out_kind = UEMR_OUT_ACK;
			end
			`UEMR_MODE_NAK_IN: begin
				in_resp = UEMR_RESP_NAK;
			end
			`UEMR_MODE_ACK_IN: begin
				in_resp = i_stall ? UEMR_RESP_STALL : UEMR_RESP_TXCNT;
			end
			`UEMR_MODE_NAKIN_STOUT: begin
				o_setup_accept = 1'b1;
				in_resp = UEMR_RESP_NAK;
				out_kind = UEMR_OUT_CHECK;
			end
			`UEMR_MODE_ACKIN_STOUT: begin
				o_setup_accept = 1'b1;
				in_resp = UEMR_RESP_TXCNT;
				out_kind = UEMR_OUT_CHECK;
			end
			default: begin
				o_setup_accept = 1'b0;
			end
		endcase
	end

	// answer by token kind; corrupt packets are never ACKed, but NAK and STALL modes still answer them
	always_comb begin
		o_out_ack_mode = (out_kind == UEMR_OUT_ACK);
		o_resp = UEMR_RESP_NONE;
		case (i_pid)
			UEMR_PID_SETUP: begin
				if (o_setup_accept && i_pkt_valid) begin
					o_resp = UEMR_RESP_ACK;
				end
			end
			UEMR_PID_IN: begin
				o_resp = in_resp;
			end
			UEMR_PID_OUT: begin
				case (out_kind)
					UEMR_OUT_NAK: o_resp = UEMR_RESP_NAK;
					UEMR_OUT_STALL: o_resp = UEMR_RESP_STALL;
					UEMR_OUT_ACK: begin
						if (i_pkt_valid) begin
							o_resp = UEMR_RESP_ACK;
						end
					end
					UEMR_OUT_CHECK: begin
						// zero length with toggle 1 passes
						if (i_pkt_valid && i_pkt_zero_len && i_pkt_toggle) begin
							o_resp = UEMR_RESP_ACK;
						end else if (i_pkt_valid) begin
							o_resp = UEMR_RESP_STALL;
						end
					end
					default: o_resp = UEMR_RESP_NONE;
				endcase
			end
			default: o_resp = UEMR_RESP_NONE;
		endcase
	end
endmodule
`default_nettype wire

// >>> hw/uemr_responder.sv
/*
 * Endpoint mode responder: mode, count and interrupt enable registers on
 * an Avalon-MM slave, the answer to each token for the control and the
 * data endpoint, automatic mode changes and gated interrupt pulses.
 * Assumes the packet front end runs on the same clock, presents one
 * token per pulse with its data packet status already known, and reports
 * host ACKs after counted transmits as a separate pulse.
 */
`default_nettype none
`include "uemr_defines.svh"
module uemr_responder (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// Avalon-MM slave
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// token from the packet front end
	input wire logic i_tok_valid,
	input wire uemr_pkg::uemr_pid_t i_tok_pid,
	input wire logic i_tok_ep,
	input wire logic i_pkt_valid,
	input wire logic i_pkt_zero_len,
	input wire logic i_pkt_toggle,
	// handshake received from the host after an IN
	input wire logic i_host_ack,
	input wire logic i_host_ack_ep,
	// answer to the packet front end
	output logic o_resp_valid,
	output uemr_pkg::uemr_resp_t o_resp,
	output logic [3:0] o_tx_count,
	// interrupt requests toward the interrupt controller
	output logic o_ctrl_ep_irq,
	output logic o_data_ep_irq
);
	import uemr_pkg::*;

	uemr_state_t s_reg;
	uemr_state_t s_next;

	// decoder inputs for the endpoint the token addresses
	logic [3:0] dec_mode;
	logic dec_stall;
	uemr_resp_t dec_resp;
	logic dec_setup_accept;
	logic dec_out_ack_mode;

	// one decoder shared by both endpoints; tokens never overlap
	assign dec_mode = i_tok_ep ? s_reg.data_mode : s_reg.ctrl_mode;
	assign dec_stall = i_tok_ep & s_reg.data_stall;

	uemr_mode_decode u_decode (
		.i_mode(dec_mode),
		.i_stall(dec_stall),
		.i_pid(i_tok_pid),
		.i_pkt_valid(i_pkt_valid),
		.i_pkt_zero_len(i_pkt_zero_len),
		.i_pkt_toggle(i_pkt_toggle),
		.o_resp(dec_resp),
		.o_setup_accept(dec_setup_accept),
		.o_out_ack_mode(dec_out_ack_mode)
	);

	// next state: bus first, then token and handshake effects
	always_comb begin
		logic req;
		logic [31:0] rd_word;
		logic ctrl_en;
		logic data_en;
		logic ev_nak_stall;
		logic ev_out_data;
		logic ev_setup;
		logic ev_tx0;
		logic [3:0] new_mode;
		logic [3:0] ack_mode;

		req = 1'b0;
		rd_word = 32'h0000_0000;
		ctrl_en = 1'b0;
		data_en = 1'b0;
		ev_nak_stall = 1'b0;
		ev_out_data = 1'b0;
		ev_setup = 1'b0;
		ev_tx0 = 1'b0;
		new_mode = 4'h0;
		ack_mode = 4'h0;

		s_next = s_reg;
		s_next.resp_valid = 1'b0;
		s_next.ctrl_irq = 1'b0;
		s_next.data_irq = 1'b0;

		// read word; unmapped offsets and reserved bits read zero
		case (i_avs_address)
			`UEMR_OFS_CTRL_MODE: rd_word[3:0] = s_reg.ctrl_mode;
			`UEMR_OFS_DATA_MODE: begin
				rd_word[3:0] = s_reg.data_mode;
				rd_word[`UEMR_STALL_BIT] = s_reg.data_stall;
			end
			`UEMR_OFS_CTRL_CNT: rd_word[3:0] = s_reg.ctrl_cnt;
			`UEMR_OFS_DATA_CNT: rd_word[3:0] = s_reg.data_cnt;
			`UEMR_OFS_IRQ_EN: rd_word[2:0] = s_reg.irq_en;
			default: rd_word = 32'h0000_0000;
		endcase

		// one wait cycle per access; data ready when wait drops
		req = i_avs_read | i_avs_write;
		s_next.avs_wait = ~(req & s_reg.avs_wait);
		if (i_avs_read && s_reg.avs_wait) begin
			s_next.rdata = rd_word;
		end

		// writes land on the edge that sees wait low
		if (i_avs_write && !s_reg.avs_wait) begin
			case (i_avs_address)
				`UEMR_OFS_CTRL_MODE: begin
					s_next.ctrl_mode = i_avs_writedata[3:0];
				end
				`UEMR_OFS_DATA_MODE: begin
					s_next.data_mode = i_avs_writedata[3:0];
					s_next.data_stall = i_avs_writedata[`UEMR_STALL_BIT];
				end
				`UEMR_OFS_CTRL_CNT: begin
					s_next.ctrl_cnt = i_avs_writedata[`UEMR_CNT_MSB:0];
				end
				`UEMR_OFS_DATA_CNT: begin
					s_next.data_cnt = i_avs_writedata[`UEMR_CNT_MSB:0];
				end
				`UEMR_OFS_IRQ_EN: begin
					s_next.irq_en = i_avs_writedata[2:0];
				end
				default: begin
					s_next.irq_en = s_reg.irq_en;
				end
			endcase
		end

		// enables: either bit of the two-bit field opens the data path
		ctrl_en = s_reg.irq_en[`UEMR_IEN_CTRL_BIT];
		data_en = |s_reg.irq_en[`UEMR_IEN_DATA_MSB:`UEMR_IEN_DATA_LSB];

		// token answer; hardware mode changes override a same-cycle write
		if (i_tok_valid) begin
			s_next.resp_valid = 1'b1;
			s_next.resp = dec_resp;
			s_next.tx_count = 4'h0;
			if (dec_resp == UEMR_RESP_TXCNT) begin
				s_next.tx_count = i_tok_ep ? s_reg.data_cnt : s_reg.ctrl_cnt;
			end

			// events of this transaction
			ev_nak_stall = (i_tok_pid != UEMR_PID_SETUP) &&
				(dec_resp == UEMR_RESP_NAK || dec_resp == UEMR_RESP_STALL);
			ev_out_data = (i_tok_pid == UEMR_PID_OUT) &&
				(dec_resp == UEMR_RESP_ACK || dec_out_ack_mode);
			ev_setup = (i_tok_pid == UEMR_PID_SETUP) && dec_setup_accept;
			ev_tx0 = (dec_resp == UEMR_RESP_TX0);

			if (!i_tok_ep) begin
				s_next.ctrl_irq = ctrl_en &
					(ev_setup | ev_tx0 | ev_out_data | ev_nak_stall);
			end else begin
				s_next.data_irq = data_en & (ev_out_data | ev_nak_stall);
			end

			// mode rewrites after an ACK we issued
			new_mode = dec_mode;
			if (i_tok_pid == UEMR_PID_OUT && dec_resp == UEMR_RESP_ACK) begin
				if (dec_mode == `UEMR_MODE_ACK_OUT) begin
					new_mode = `UEMR_MODE_NAK_OUT;
				end else if (dec_mode == `UEMR_MODE_ACKOUT_NAKIN) begin
					new_mode = `UEMR_MODE_NAK_INOUT;
				end
			end
			if (i_tok_pid == UEMR_PID_SETUP && dec_resp == UEMR_RESP_ACK &&
				!i_tok_ep && dec_mode != `UEMR_MODE_DISABLED) begin
				new_mode = `UEMR_MODE_NAK_INOUT;
			end
			if (new_mode != dec_mode) begin
				if (i_tok_ep) begin
					s_next.data_mode = new_mode;
				end else begin
					s_next.ctrl_mode = new_mode;
				end
			end
		end else if (i_host_ack) begin
			// host ACK closes a counted IN; the mode drops to its NAK form
			ack_mode = i_host_ack_ep ? s_reg.data_mode : s_reg.ctrl_mode;
			new_mode = ack_mode;
			if (ack_mode == `UEMR_MODE_ACKIN_STOUT) begin
				new_mode = `UEMR_MODE_NAKIN_STOUT;
			end else if (ack_mode == `UEMR_MODE_ACK_IN) begin
				new_mode = `UEMR_MODE_NAK_IN;
			end
			if (i_host_ack_ep) begin
				s_next.data_mode = new_mode;
				s_next.data_irq = data_en;
			end else begin
				s_next.ctrl_mode = new_mode;
			end
		end
	end

	// state register; modes come out of reset disabled
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			s_reg <= '0;
			s_reg.ctrl_mode <= `UEMR_RST_MODE;
			s_reg.data_mode <= `UEMR_RST_MODE;
			s_reg.ctrl_cnt <= `UEMR_RST_CNT;
			s_reg.data_cnt <= `UEMR_RST_CNT;
			s_reg.irq_en <= `UEMR_RST_IEN;
			s_reg.avs_wait <= 1'b1;
			s_reg.resp <= UEMR_RESP_NONE;
		end else begin
			s_reg <= s_next;
		end
	end

	// every output straight from the state register
	assign o_avs_readdata = s_reg.rdata;
	assign o_avs_waitrequest = s_reg.avs_wait;
	assign o_resp_valid = s_reg.resp_valid;
	assign o_resp = s_reg.resp;
	assign o_tx_count = s_reg.tx_count;
	assign o_ctrl_ep_irq = s_reg.ctrl_irq;
	assign o_data_ep_irq = s_reg.data_irq;
endmodule
`default_nettype wire

// >>> dv/uemr_host_model.sv
/*
 * Host side model: issues tokens and host ACKs as one-cycle pulses.
 * Assumes it shares the responder clock and is driven by bench tasks.
 */
`default_nettype none
module uemr_host_model (
	// clock
	input wire logic i_ref_clk,
	// token link toward the responder
	output logic o_tok_valid,
	output uemr_pkg::uemr_pid_t o_tok_pid,
	output logic o_tok_ep,
	output logic o_pkt_valid,
	output logic o_pkt_zero_len,
	output logic o_pkt_toggle,
	// handshake from the host after an IN
	output logic o_host_ack,
	output logic o_host_ack_ep
);
	timeunit 1ns;
	timeprecision 1ps;
	import uemr_pkg::*;

	// idle link at time zero
	initial begin
		o_tok_valid = 1'b0;
		o_tok_pid = UEMR_PID_IN;
		o_tok_ep = 1'b0;
		o_pkt_valid = 1'b0;
		o_pkt_zero_len = 1'b0;
		o_pkt_toggle = 1'b0;
		o_host_ack = 1'b0;
		o_host_ack_ep = 1'b0;
	end

	// one token pulse; qualifiers flip after it so stale values never help
	task automatic send(input uemr_pid_t p, input logic e, v, z, g);
		@(posedge i_ref_clk);
		o_tok_valid <= 1'b1;
		o_tok_pid <= p;
		o_tok_ep <= e;
		o_pkt_valid <= v;
		o_pkt_zero_len <= z;
		o_pkt_toggle <= g;
		@(posedge i_ref_clk);
		o_tok_valid <= 1'b0;
		o_tok_ep <= ~e;
		o_pkt_valid <= ~v;
		o_pkt_zero_len <= ~z;
		o_pkt_toggle <= ~g;
	endtask

	// host ACK pulse closing an IN transmit
	task automatic ack(input logic e);
		@(posedge i_ref_clk);
		o_host_ack <= 1'b1;
		o_host_ack_ep <= e;
		@(posedge i_ref_clk);
		o_host_ack <= 1'b0;
		o_host_ack_ep <= ~e;
	endtask
endmodule
`default_nettype wire

// >>> dv/uemr_responder_asserts.sv
/*
 * Checker for the endpoint mode responder, bound to its ports.
 * Assumes one clock and the synchronous active low reset.
 */
`default_nettype none
module uemr_responder_asserts (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// bus, token and host ACK inputs
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic i_tok_valid,
	input wire uemr_pkg::uemr_pid_t i_tok_pid,
	input wire logic i_tok_ep,
	input wire logic i_pkt_valid,
	input wire logic i_host_ack,
	input wire logic i_host_ack_ep,
	// design outputs
	input wire logic o_avs_waitrequest,
	input wire logic o_resp_valid,
	input wire uemr_pkg::uemr_resp_t o_resp,
	input wire logic [3:0] o_tx_count,
	input wire logic o_ctrl_ep_irq,
	input wire logic o_data_ep_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	import uemr_pkg::*;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);

	// one wait state, then back to high
	bus_wait_a: assert property ((i_avs_read || i_avs_write) &&
		o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
		else $error("bus answer not after one wait state");
	resp_lat_a: assert property (i_tok_valid |=> o_resp_valid)
		else $error("token answer missing");
	resp_hold_a: assert property (!o_resp_valid |-> $stable(o_resp))
		else $error("answer changed without a token");
	setup_resp_a: assert property (i_tok_valid &&
		i_tok_pid == UEMR_PID_SETUP |=> o_resp inside {UEMR_RESP_NONE,
		UEMR_RESP_ACK}) else $error("bad answer to SETUP");
	out_resp_a: assert property (i_tok_valid && i_tok_pid == UEMR_PID_OUT
		|=> !(o_resp inside {UEMR_RESP_TX0, UEMR_RESP_TXCNT}))
		else $error("data sent on OUT");
	bad_pkt_a: assert property (i_tok_valid && !i_pkt_valid &&
		i_tok_pid == UEMR_PID_OUT |=> o_resp != UEMR_RESP_ACK)
		else $error("invalid OUT acknowledged");
	tx_zero_a: assert property (o_resp != UEMR_RESP_TXCNT |->
		o_tx_count == 4'h0) else $error("count without transmit");
	ctrl_src_a: assert property (o_ctrl_ep_irq |->
		$past(i_tok_valid && !i_tok_ep)) else $error("stray control irq");
	data_src_a: assert property (o_data_ep_irq |->
		$past(i_tok_valid && i_tok_ep || i_host_ack && i_host_ack_ep))
		else $error("stray data irq");

	cover property (o_resp_valid && o_resp == UEMR_RESP_TXCNT);
	cover property (o_data_ep_irq && $past(i_host_ack));
	cover property (o_resp_valid && o_resp == UEMR_RESP_ACK);
endmodule

bind uemr_responder uemr_responder_asserts chk_u (
	.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_avs_read(i_avs_read),
	.i_avs_write(i_avs_write), .i_tok_valid(i_tok_valid),
	.i_tok_pid(i_tok_pid), .i_tok_ep(i_tok_ep), .i_pkt_valid(i_pkt_valid),
	.i_host_ack(i_host_ack), .i_host_ack_ep(i_host_ack_ep),
	.o_avs_waitrequest(o_avs_waitrequest), .o_resp_valid(o_resp_valid),
	.o_resp(o_resp), .o_tx_count(o_tx_count),
	.o_ctrl_ep_irq(o_ctrl_ep_irq), .o_data_ep_irq(o_data_ep_irq)
);
`default_nettype wire

// >>> dv/uemr_responder_tb.sv
/*
 * Bench for the endpoint mode responder: Avalon tasks, host model and
 * one task per scenario. Assumes the checker is bound to the design.
 */
`default_nettype none
module uemr_responder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import uemr_pkg::*;
	logic i_ref_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic [4:0] adr = 5'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdq, q;
	logic tok_v, tok_e, pk_v, pk_z, pk_g, h_ack, h_ep, rv, ci, di, wt;
	uemr_pid_t tok_p;
	uemr_resp_t rs;
	logic [3:0] tc;
	int n_fail = 0;
	int n_compared = 0;

	uemr_responder dut_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .o_avs_readdata(rdq),
		.o_avs_waitrequest(wt), .i_tok_valid(tok_v), .i_tok_pid(tok_p),
		.i_tok_ep(tok_e), .i_pkt_valid(pk_v), .i_pkt_zero_len(pk_z),
		.i_pkt_toggle(pk_g), .i_host_ack(h_ack), .i_host_ack_ep(h_ep),
		.o_resp_valid(rv), .o_resp(rs), .o_tx_count(tc),
		.o_ctrl_ep_irq(ci), .o_data_ep_irq(di));
	uemr_host_model host_u (.i_ref_clk(i_ref_clk), .o_tok_valid(tok_v),
		.o_tok_pid(tok_p), .o_tok_ep(tok_e), .o_pkt_valid(pk_v),
		.o_pkt_zero_len(pk_z), .o_pkt_toggle(pk_g), .o_host_ack(h_ack),
		.o_host_ack_ep(h_ep));

	// 200 MHz clock
	initial begin
		forever #2.5 i_ref_clk = ~i_ref_clk;
	end

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("Error t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask

	// one Avalon access, held until waitrequest is sampled low
	// no cycle limit here: a hung slave is caught by the watchdog
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		@(posedge i_ref_clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge i_ref_clk);
		end while (wt !== 1'b0);
		q = rdq;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	// token, then the one-cycle answer and irq pulse are judged
	task automatic tok(input uemr_pid_t p, input logic e, v, z, g,
		input uemr_resp_t r, input logic irq);
		host_u.send(p, e, v, z, g);
		#1;
		chk(32'(rv), 32'h1);
		chk(32'(rs), 32'(r));
		chk(32'(e ? di : ci), 32'(irq));
	endtask

	// expected control answer; k: 0 SETUP, 1 IN, 2 good OUT, 3 toggle 0
	function automatic uemr_resp_t ref_resp(input logic [3:0] m,
		input logic [1:0] k);
		if (k == 2'h0)
			return m inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'hA, 4'hB,
				4'hE, 4'hF} ? UEMR_RESP_ACK : UEMR_RESP_NONE;
		if (k == 2'h1)
			case (m)
				4'h1, 4'hB, 4'hC, 4'hE: return UEMR_RESP_NAK;
				4'h2, 4'h3: return UEMR_RESP_STALL;
				4'h6, 4'hA: return UEMR_RESP_TX0;
				4'hD, 4'hF: return UEMR_RESP_TXCNT;
				default: return UEMR_RESP_NONE;
			endcase
		case (m)
			4'h1, 4'h8, 4'hA: return UEMR_RESP_NAK;
			4'h3, 4'h6: return UEMR_RESP_STALL;
			4'h9, 4'hB: return UEMR_RESP_ACK;
			4'h2, 4'hE, 4'hF:
				return k == 2'h2 ? UEMR_RESP_ACK : UEMR_RESP_STALL;
			default: return UEMR_RESP_NONE;
		endcase
	endfunction

	task automatic t_regs();
		for (int a = 0; a < 5; a++)
			rd_chk(5'(a * 4), 32'h0);
		bus(1'b1, 5'h10, 32'hFF);
		rd_chk(5'h10, 32'h7);
		bus(1'b1, 5'h14, 32'hFF);
		rd_chk(5'h14, 32'h0);
		$display("registers test done");
	endtask

	// every usable mode against every token on the control endpoint
	task automatic t_modes();
		uemr_resp_t r;
		uemr_pid_t p;
		logic [3:0] m, nm;
		logic [1:0] k;
		logic ei;
		bus(1'b1, 5'h08, 32'hF);
		for (int i = 0; i < 64; i++) begin
			m = 4'(i / 4);
			k = 2'(i);
			if (m == 4'h5 || m == 4'h7)
				continue; // reserved encodings never programmed
			r = ref_resp(m, k);
			p = k == 2'h0 ? UEMR_PID_SETUP :
				(k == 2'h1 ? UEMR_PID_IN : UEMR_PID_OUT);
			ei = r inside {UEMR_RESP_ACK, UEMR_RESP_NAK, UEMR_RESP_STALL,
				UEMR_RESP_TX0};
			nm = m;
			if (r == UEMR_RESP_ACK && (k == 2'h0 || m == 4'hB))
				nm = 4'h1;
			if (r == UEMR_RESP_ACK && m == 4'h9)
				nm = 4'h8;
			bus(1'b1, 5'h00, 32'(m));
			tok(p, 1'b0, 1'b1, 1'b1, k != 2'h3, r, ei);
			chk(32'(tc), r == UEMR_RESP_TXCNT ? 32'hF : 32'h0);
			rd_chk(5'h00, 32'(nm));
		end
		$display("mode table test done");
	endtask

	task automatic t_data();
		bus(1'b1, 5'h0C, 32'h5);
		bus(1'b1, 5'h04, 32'hD);
		tok(UEMR_PID_IN, 1'b1, 1'b1, 1'b0, 1'b0, UEMR_RESP_TXCNT, 1'b0);
		chk(32'(tc), 32'h5);
		host_u.ack(1'b1);
		#1;
		chk(32'(di), 32'h1);
		rd_chk(5'h04, 32'hC);
		bus(1'b1, 5'h04, 32'h8D);
		tok(UEMR_PID_IN, 1'b1, 1'b1, 1'b0, 1'b0, UEMR_RESP_STALL, 1'b1);
		bus(1'b1, 5'h04, 32'h89);
		tok(UEMR_PID_OUT, 1'b1, 1'b1, 1'b0, 1'b0, UEMR_RESP_STALL, 1'b1);
		bus(1'b1, 5'h04, 32'h09);
		tok(UEMR_PID_OUT, 1'b1, 1'b0, 1'b0, 1'b0, UEMR_RESP_NONE, 1'b1);
		tok(UEMR_PID_OUT, 1'b1, 1'b1, 1'b0, 1'b0, UEMR_RESP_ACK, 1'b1);
		tok(UEMR_PID_OUT, 1'b1, 1'b1, 1'b0, 1'b0, UEMR_RESP_NAK, 1'b1);
		bus(1'b1, 5'h00, 32'hF);
		host_u.ack(1'b0);
		#1;
		chk(32'(ci), 32'h0);
		rd_chk(5'h00, 32'hE);
		// check mode: a long valid packet stalls, a corrupt one stays silent
		tok(UEMR_PID_OUT, 1'b0, 1'b1, 1'b0, 1'b1, UEMR_RESP_STALL, 1'b1);
		tok(UEMR_PID_OUT, 1'b0, 1'b0, 1'b1, 1'b1, UEMR_RESP_NONE, 1'b0);
		rd_chk(5'h00, 32'hE);
		$display("data endpoint test done");
	endtask

	// enables gate each endpoint; data enable is either of its two bits
	task automatic t_mask();
		bus(1'b1, 5'h10, 32'h0);
		tok(UEMR_PID_IN, 1'b0, 1'b1, 1'b0, 1'b0, UEMR_RESP_NAK, 1'b0);
		tok(UEMR_PID_OUT, 1'b1, 1'b1, 1'b0, 1'b0, UEMR_RESP_NAK, 1'b0);
		bus(1'b1, 5'h10, 32'h4);
		tok(UEMR_PID_OUT, 1'b1, 1'b1, 1'b0, 1'b0, UEMR_RESP_NAK, 1'b1);
		tok(UEMR_PID_IN, 1'b0, 1'b1, 1'b0, 1'b0, UEMR_RESP_NAK, 1'b0);
		bus(1'b1, 5'h10, 32'h2);
		tok(UEMR_PID_OUT, 1'b1, 1'b1, 1'b0, 1'b0, UEMR_RESP_NAK, 1'b1);
		bus(1'b1, 5'h10, 32'h1);
		tok(UEMR_PID_IN, 1'b0, 1'b1, 1'b0, 1'b0, UEMR_RESP_NAK, 1'b1);
		$display("enable test done");
	endtask

	// watchdog well beyond the six hundred or so cycles the tests take
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		n_fail++;
		wrap_up();
	end

	initial begin
		repeat (6) @(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		t_regs();
		t_modes();
		t_data();
		t_mask();
		wrap_up();
	end
endmodule
`default_nettype wire
